/* File: include/evm_pkg.sv */
`default_nettype none
package evm_pkg;
   localparam int NVEC     = 60;
   localparam int NUM_IRQ  = 44;
   localparam int VEC_W    = 6;
   localparam int PRI_W    = 3;
   localparam int RANK_W   = 4;
   localparam int OFF_W    = 8;

   localparam logic [VEC_W-1:0] VEC_NMI   = 6'h02;
   localparam logic [VEC_W-1:0] VEC_HARD  = 6'h03;
   localparam logic [VEC_W-1:0] VEC_MEM   = 6'h04;
   localparam logic [VEC_W-1:0] VEC_BUS   = 6'h05;
   localparam logic [VEC_W-1:0] VEC_USAGE = 6'h06;
   localparam logic [VEC_W-1:0] VEC_IRQ0  = 6'h10;
   localparam logic [VEC_W-1:0] VEC_LAST  = 6'h3b;

   localparam logic [OFF_W-1:0] STACK_TOP_OFF = 8'h00;
   localparam logic [OFF_W-1:0] RESET_OFF     = 8'h04;
   localparam logic [OFF_W-1:0] IRQ_TABLE_OFF = 8'h40;

   // Bit n stands for vector number n
   localparam logic [NVEC-1:0] IMPL_MASK  = 60'h83f_f7fc_01ff_d87c;
   localparam logic [NVEC-1:0] CFG_MASK   = 60'h83f_f7fc_01ff_d870;
   localparam logic [NVEC-1:0] ASYNC_MASK = 60'h83f_f7fc_01ff_c004;
   localparam logic [NVEC-1:0] FAULT_MASK = 60'h000_0000_0000_0070;
   localparam logic [NVEC-1:0] EN_RESET   = 60'h0;

   localparam logic [PRI_W-1:0]  PRI_RESET = 3'h0;
   localparam logic [RANK_W-1:0] RANK_NMI  = 4'h1;
   localparam logic [RANK_W-1:0] RANK_HARD = 4'h2;
   localparam logic [RANK_W-1:0] RANK_CFG0 = 4'h3;
   localparam logic [RANK_W-1:0] RANK_NONE = 4'hf;

   typedef enum logic [1:0] {
      BOOT_SP = 2'b00,
      BOOT_PC = 2'b01,
      BOOT_RUN = 2'b10
   } evm_boot_t;
endpackage : evm_pkg
`default_nettype wire

/* File: include/evm_cfg_if.sv */
`default_nettype none
interface evm_cfg_if;
   logic                                        wr_en;
   logic [evm_pkg::VEC_W-1:0]                   wr_vec;
   logic [evm_pkg::PRI_W-1:0]                   wr_pri;
   logic [evm_pkg::NVEC*evm_pkg::PRI_W-1:0]     pri_flat;

   modport store (input wr_en, input wr_vec, input wr_pri, output pri_flat);
   modport user  (output wr_en, output wr_vec, output wr_pri, input pri_flat);
endinterface : evm_cfg_if
`default_nettype wire

/* File: rtl/evm_pri_store.sv */
`default_nettype none
module evm_pri_store #(
   parameter int NENT = evm_pkg::NVEC
) (
   input  wire logic    clock,
   input  wire logic    rst_n,
   evm_cfg_if.store     cfg
);
   logic [evm_pkg::PRI_W-1:0] pri_mem_r [NENT];

   // Entries are flops so every priority is seen by the arbiter at once
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NENT; i++) begin
            pri_mem_r[i] <= evm_pkg::PRI_RESET;
         end
      end else if (cfg.wr_en) begin
         pri_mem_r[cfg.wr_vec] <= cfg.wr_pri;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NENT; g++) begin : g_flat
         assign cfg.pri_flat[g*evm_pkg::PRI_W +: evm_pkg::PRI_W] =
            pri_mem_r[g];
      end
   endgenerate
endmodule : evm_pri_store
`default_nettype wire

/* File: rtl/evm_vector_map.sv */
`default_nettype none
module evm_vector_map (
   input  wire logic                               clock,
   input  wire logic                               rst_n,
   input  wire logic                               src_nmi,
   input  wire logic                               src_hard_fault,
   input  wire logic                               src_mem_fault,
   input  wire logic                               src_bus_precise,
   input  wire logic                               src_bus_imprecise,
   input  wire logic                               src_usage_fault,
   input  wire logic                               src_svc,
   input  wire logic                               src_debug_mon,
   input  wire logic                               src_pendable_service_exception,
   input  wire logic                               src_system_tick_exception,
   input  wire logic [evm_pkg::NUM_IRQ-1:0]        src_irq,
   input  wire logic                               cfg_wr,
   input  wire logic                               cfg_priv,
   input  wire logic                               cfg_sel_en,
   input  wire logic [evm_pkg::VEC_W-1:0]          cfg_vec,
   input  wire logic [evm_pkg::PRI_W-1:0]          cfg_data,
   output logic                                    boot_fetch_req,
   output logic [evm_pkg::OFF_W-1:0]               boot_fetch_off,
   input  wire logic                               boot_fetch_ack,
   output logic                                    exc_req,
   output logic [evm_pkg::VEC_W-1:0]               exc_vec,
   output logic [evm_pkg::OFF_W-1:0]               exc_offset,
   output logic [evm_pkg::RANK_W-1:0]              exc_rank,
   output logic                                    exc_async,
   input  wire logic                               exc_ack
);
   localparam int N = evm_pkg::NVEC;
   localparam int RANK_W = evm_pkg::RANK_W;

   evm_pkg::evm_boot_t               state_r;
   evm_pkg::evm_boot_t               state_nxt;
   logic [evm_pkg::OFF_W-1:0]        boot_off_r;
   logic [N-1:0]                     pend_r;
   logic [N-1:0]                     pend_nxt;
   logic [N-1:0]                     en_r;
   logic [N-1:0]                     en_nxt;
   logic                             bf_async_r;
   logic                             bf_async_nxt;
   logic                             req_r;
   logic [evm_pkg::VEC_W-1:0]        vec_r;
   logic [evm_pkg::RANK_W-1:0]       rank_r;
   logic                             async_r;
   logic [N-1:0]                     set_raw_w;
   logic [N-1:0]                     set_w;
   logic [N-1:0]                     clr_w;
   logic [N-1:0]                     elig_w;
   logic [N-1:0]                     vec_bit_w;
   logic                             escalate_w;
   logic                             cfg_ok_w;
   logic                             en_wr_w;
   logic                             load_w;
   logic                             ack_w;
   logic [evm_pkg::RANK_W-1:0]       rank_a [N];
   logic [evm_pkg::RANK_W-1:0]       best_rank;
   logic [evm_pkg::VEC_W-1:0]        best_vec;
   logic                             best_async_w;

   evm_cfg_if cfg_bus ();

   evm_pri_store #(.NENT(N)) u_pri (
      .clock (clock),
      .rst_n (rst_n),
      .cfg   (cfg_bus.store)
   );

   ////////////////////////////////////////////////////////////////////////
   // Configuration writes
   assign cfg_ok_w = cfg_wr && cfg_priv && (cfg_vec <= evm_pkg::VEC_LAST)
                     && evm_pkg::CFG_MASK[cfg_vec];
   assign en_wr_w  = cfg_ok_w && cfg_sel_en;
   assign cfg_bus.wr_en  = cfg_ok_w && !cfg_sel_en;
   assign cfg_bus.wr_vec = cfg_vec;
   assign cfg_bus.wr_pri = cfg_data;
   assign en_nxt = en_wr_w ?
      ((en_r & ~(N'(1) << cfg_vec)) | (N'(cfg_data[0]) << cfg_vec)) : en_r;

   ////////////////////////////////////////////////////////////////////////
   // Pending state
   // A disabled fault cannot be taken, so it escalates to hard fault
   assign escalate_w = (src_mem_fault && !en_r[evm_pkg::VEC_MEM])
      || ((src_bus_precise || src_bus_imprecise) && !en_r[evm_pkg::VEC_BUS])
      || (src_usage_fault && !en_r[evm_pkg::VEC_USAGE]);
   assign set_raw_w = {src_irq, src_system_tick_exception, src_pendable_service_exception, 1'b0,
                       src_debug_mon, src_svc, 4'h0, src_usage_fault,
                       src_bus_precise || src_bus_imprecise, src_mem_fault,
                       src_hard_fault || escalate_w, src_nmi, 2'b00};
   assign set_w = set_raw_w & evm_pkg::IMPL_MASK
                  & ~(evm_pkg::FAULT_MASK & ~en_r);
   assign ack_w     = req_r && exc_ack;
   assign vec_bit_w = N'(1) << vec_r;
   assign clr_w     = ack_w ? vec_bit_w : '0;
   assign pend_nxt  = (pend_r & ~clr_w) | set_w;
   // Fixed exceptions bypass the enable bits
   assign elig_w = pend_r & evm_pkg::IMPL_MASK
                   & (en_r | ~evm_pkg::CFG_MASK);
   assign bf_async_nxt = src_bus_imprecise ? 1'b1 :
      ((src_bus_precise || (ack_w && vec_r == evm_pkg::VEC_BUS)) ?
       1'b0 : bf_async_r);

   ////////////////////////////////////////////////////////////////////////
   // Arbitration
   always_comb begin
      for (int i = 0; i < N; i++) begin
         rank_a[i] = evm_pkg::RANK_CFG0 + RANK_W'(
            cfg_bus.pri_flat[i*evm_pkg::PRI_W +: evm_pkg::PRI_W]);
      end
      rank_a[evm_pkg::VEC_NMI]  = evm_pkg::RANK_NMI;
      rank_a[evm_pkg::VEC_HARD] = evm_pkg::RANK_HARD;
   end

   // Downward scan with <= leaves the lowest number among equal ranks
   always_comb begin
      best_rank = evm_pkg::RANK_NONE;
      best_vec  = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (elig_w[i] && rank_a[i] <= best_rank) begin
            best_rank = rank_a[i];
            best_vec  = evm_pkg::VEC_W'(i);
         end
      end
   end

   assign best_async_w = (best_vec == evm_pkg::VEC_BUS) ? bf_async_r :
                         evm_pkg::ASYNC_MASK[best_vec];
   // One idle cycle after each ack lets the cleared bit settle
   assign load_w = (state_r == evm_pkg::BOOT_RUN) && !req_r
                   && (best_rank != evm_pkg::RANK_NONE);

   ////////////////////////////////////////////////////////////////////////
   // Boot sequence
   always_comb begin
      case (state_r)
         evm_pkg::BOOT_SP:
            state_nxt = boot_fetch_ack ? evm_pkg::BOOT_PC : evm_pkg::BOOT_SP;
         evm_pkg::BOOT_PC:
            state_nxt = boot_fetch_ack ? evm_pkg::BOOT_RUN : evm_pkg::BOOT_PC;
         evm_pkg::BOOT_RUN:
            state_nxt = evm_pkg::BOOT_RUN;
         default:
            state_nxt = evm_pkg::BOOT_SP;
      endcase
   end

   assign boot_fetch_req = (state_r != evm_pkg::BOOT_RUN);
   assign boot_fetch_off = boot_off_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= evm_pkg::BOOT_SP;
         boot_off_r <= evm_pkg::STACK_TOP_OFF;
      end else begin
         state_r    <= state_nxt;
         boot_off_r <= (state_nxt == evm_pkg::BOOT_SP) ?
                       evm_pkg::STACK_TOP_OFF : evm_pkg::RESET_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State and request registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_r     <= '0;
         en_r       <= evm_pkg::EN_RESET;
         bf_async_r <= 1'b0;
      end else begin
         pend_r     <= pend_nxt;
         en_r       <= en_nxt;
         bf_async_r <= bf_async_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_r   <= 1'b0;
         vec_r   <= '0;
         rank_r  <= evm_pkg::RANK_NONE;
         async_r <= 1'b0;
      end else if (load_w) begin
         req_r   <= 1'b1;
         vec_r   <= best_vec;
         rank_r  <= best_rank;
         async_r <= best_async_w;
      end else if (ack_w) begin
         req_r   <= 1'b0;
      end
   end

   assign exc_req    = req_r;
   assign exc_vec    = vec_r;
   assign exc_offset = {vec_r, 2'b00};
   assign exc_rank   = rank_r;
   assign exc_async  = async_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic          first_r;
   logic [N-1:0]  elig_past_r;
   logic          beaten_w;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         first_r     <= 1'b1;
         elig_past_r <= '0;
      end else begin
         first_r     <= 1'b0;
         elig_past_r <= elig_w;
      end
   end
   always_comb begin
      beaten_w = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (elig_past_r[i] && (rank_a[i] < rank_r ||
             (rank_a[i] == rank_r && evm_pkg::VEC_W'(i) < vec_r))) begin
            beaten_w = 1'b1;
         end
      end
   end

   sequence s_sp_taken;
      boot_fetch_req && boot_fetch_off == 8'h00 && boot_fetch_ack;
   endsequence
   sequence s_pc_offered;
      boot_fetch_req && boot_fetch_off == 8'h04;
   endsequence

   property p_boot_order;
      s_sp_taken |=> s_pc_offered;
   endproperty
   a_boot_order: assert property (p_boot_order)
      else $error("reset vector not fetched after stack top");

   property p_boot_first;
      first_r |-> boot_fetch_req && boot_fetch_off == 8'h00 && !exc_req;
   endproperty
   a_boot_first: assert property (p_boot_first)
      else $error("stack top is not the first fetch");

   property p_pri_reset;
      first_r |-> cfg_bus.pri_flat == '0;
   endproperty
   a_pri_reset: assert property (p_pri_reset)
      else $error("priority not zero after reset");

   property p_no_reserved;
      (pend_r & ~evm_pkg::IMPL_MASK) == '0
      && (!exc_req || evm_pkg::IMPL_MASK[exc_vec]);
   endproperty
   a_no_reserved: assert property (p_no_reserved)
      else $error("reserved vector pending or requested");

   property p_disabled_quiet;
      $rose(exc_req) && evm_pkg::CFG_MASK[exc_vec]
      |-> elig_past_r[exc_vec];
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled exception requested");

   property p_nmi_first;
      state_r == evm_pkg::BOOT_RUN && !req_r && pend_r[2]
      |=> exc_req && exc_vec == 6'h02 && exc_rank == 4'h1;
   endproperty
   a_nmi_first: assert property (p_nmi_first)
      else $error("non-maskable interrupt not taken first");

   property p_hard_next;
      state_r == evm_pkg::BOOT_RUN && !req_r && pend_r[3] && !pend_r[2]
      |=> exc_req && exc_vec == 6'h03 && exc_rank == 4'h2;
   endproperty
   a_hard_next: assert property (p_hard_next)
      else $error("hard fault not above configurable");

   property p_best_win;
      $rose(exc_req) |-> !beaten_w && exc_rank <= 4'ha;
   endproperty
   a_best_win: assert property (p_best_win)
      else $error("granted exception was not the best");

   property p_sync_kinds;
      exc_req && (exc_vec == 6'h04 || exc_vec == 6'h06 ||
                  exc_vec == 6'h0b || exc_vec == 6'h0c) |-> !exc_async;
   endproperty
   a_sync_kinds: assert property (p_sync_kinds)
      else $error("synchronous exception marked asynchronous");

   property p_async_kinds;
      exc_req && exc_vec >= 6'h0e |-> exc_async;
   endproperty
   a_async_kinds: assert property (p_async_kinds)
      else $error("asynchronous exception not marked");

   property p_irq_offset;
      exc_req && exc_vec >= 6'h10
      |-> exc_offset == 8'(8'h40 + 8'(exc_vec - 6'h10) * 8'h04);
   endproperty
   a_irq_offset: assert property (p_irq_offset)
      else $error("interrupt vector offset wrong");
endmodule : evm_vector_map
`default_nettype wire

/* File: dv/evm_core_model.sv */
`default_nettype none
module evm_core_model (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic boot_fetch_req,
   output var logic  boot_fetch_ack,
   input  wire logic exc_req,
   output var logic  exc_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_n;
   ////////////////////////////////////////////////////////////////////////
   // Random stall so that every offer has to stand until taken
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_fetch_ack <= 1'b0;
         exc_ack        <= 1'b0;
         wait_n = 0;
      end else if (boot_fetch_ack || exc_ack) begin
         boot_fetch_ack <= 1'b0;
         exc_ack        <= 1'b0;
         wait_n = $urandom % 3;
      end else if (wait_n > 0) begin
         wait_n--;
      end else begin
         boot_fetch_ack <= boot_fetch_req;
         exc_ack        <= exc_req;
      end
   end
endmodule : evm_core_model
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [5:0] vec;
      logic [3:0] rank;
      logic       async;
   } evm_exp_t;
   localparam logic [5:0] SV [10] = '{2, 3, 4, 5, 5, 6, 11, 12, 14, 15};
   localparam logic [9:0] SA = 10'h311;
   logic        clock;
   logic        rst_n;
   logic [9:0]  src_sys;
   logic [43:0] src_irq;
   logic        cfg_wr;
   logic        cfg_priv;
   logic        cfg_sel_en;
   logic [5:0]  cfg_vec;
   logic [2:0]  cfg_data;
   logic        boot_fetch_req;
   logic [7:0]  boot_fetch_off;
   logic        boot_fetch_ack;
   logic        exc_req;
   logic [5:0]  exc_vec;
   logic [7:0]  exc_offset;
   logic [3:0]  exc_rank;
   logic        exc_async;
   logic        exc_ack;
   int          err_total;
   int          n_tests;
   evm_exp_t    exp_q[$];
   evm_exp_t    e;
   logic [7:0]  boot_q[$];
   ////////////////////////////////////////////////////////////////////////
   evm_vector_map DUT (
      .clock(clock), .rst_n(rst_n),
      .src_nmi(src_sys[0]), .src_hard_fault(src_sys[1]),
      .src_mem_fault(src_sys[2]), .src_bus_precise(src_sys[3]),
      .src_bus_imprecise(src_sys[4]), .src_usage_fault(src_sys[5]),
      .src_svc(src_sys[6]), .src_debug_mon(src_sys[7]),
      .src_pendable_service_exception(src_sys[8]), .src_system_tick_exception(src_sys[9]),
      .src_irq(src_irq), .cfg_wr(cfg_wr), .cfg_priv(cfg_priv),
      .cfg_sel_en(cfg_sel_en), .cfg_vec(cfg_vec), .cfg_data(cfg_data),
      .boot_fetch_req(boot_fetch_req), .boot_fetch_off(boot_fetch_off),
      .boot_fetch_ack(boot_fetch_ack), .exc_req(exc_req),
      .exc_vec(exc_vec), .exc_offset(exc_offset), .exc_rank(exc_rank),
      .exc_async(exc_async), .exc_ack(exc_ack));
   evm_core_model core (
      .clock(clock), .rst_n(rst_n), .boot_fetch_req(boot_fetch_req),
      .boot_fetch_ack(boot_fetch_ack), .exc_req(exc_req),
      .exc_ack(exc_ack));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] x, y);
      n_tests++;
      if (y !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, x, y);
      end
   endtask : check
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   task automatic cfg(input logic pv, en, input logic [5:0] v,
                      input logic [2:0] d);
      @(posedge clock);
      cfg_wr     <= 1'b1;
      cfg_priv   <= pv;
      cfg_sel_en <= en;
      cfg_vec    <= v;
      cfg_data   <= d;
      @(posedge clock);
      cfg_wr     <= 1'b0;
   endtask : cfg
   // One-cycle pulse: pending latches it, so no re-pend after the ack
   task automatic fire(input logic [9:0] s, input logic [43:0] q);
      @(posedge clock);
      src_sys <= s;
      src_irq <= q;
      @(posedge clock);
      src_sys <= '0;
      src_irq <= '0;
   endtask : fire
   task automatic push(input int v, r, a);
      exp_q.push_back(evm_exp_t'{vec: 6'(v), rank: 4'(r), async: 1'(a)});
   endtask : push
   // Quiet tail lets the monitor catch offers nobody expected
   task automatic settle(input string nm);
      int k;
      k = 0;
      while ((exp_q.size() != 0 || exc_req || boot_fetch_req) && k < 80) begin
         @(posedge clock);
         #1;
         k++;
      end
      if (k == 80) begin
         err_total++;
         $display("ERROR idle expected 1 seen 0");
         complete_run();
      end
      repeat (12) @(posedge clock);
      $display("test %s done", nm);
   endtask : settle
   function automatic bit impl(input int n);
      return n <= 8 || (n >= 18 && n <= 26) || (n >= 28 && n <= 37) ||
             n == 43;
   endfunction : impl
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (rst_n && boot_fetch_req && boot_fetch_ack) begin
         check("boot_fetch_off", boot_q.pop_front(), boot_fetch_off);
      end
      if (rst_n && exc_req && exc_ack) begin
         if (exp_q.size() == 0) begin
            check("unexpected exc_vec", 8'hff, {2'b00, exc_vec});
         end else begin
            e = exp_q.pop_front();
            check("exc_vec", {2'b00, e.vec}, {2'b00, exc_vec});
            check("exc_offset", {e.vec, 2'b00}, exc_offset);
            check("exc_rank", {4'h0, e.rank}, {4'h0, exc_rank});
            check("exc_async", {7'h0, e.async}, {7'h0, exc_async});
         end
      end
   end
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      int n;
      int p;
      rst_n = 1'b0;
      src_sys = '0;
      src_irq = '0;
      cfg_wr = 1'b0;
      cfg_priv = 1'b0;
      cfg_sel_en = 1'b0;
      cfg_vec = '0;
      cfg_data = '0;
      void'($urandom(32'hc1bda999));
      repeat (5) @(posedge clock);
      check("boot_fetch_req", 8'h01, {7'h0, boot_fetch_req});
      check("exc_req", 8'h00, {7'h0, exc_req});
      boot_q.push_back(8'h00);
      boot_q.push_back(8'h04);
      rst_n <= 1'b1;
      settle("boot");
      cfg(1, 1, 16, 1);
      cfg(1, 1, 17, 1);
      push(16, 3, 1);
      fire(0, 44'h1);
      settle("reset_priority");
      foreach (SV[i]) begin
         if (i > 1) cfg(1, 1, SV[i], 1);
      end
      for (int i = 0; i < 10; i++) begin
         p = $urandom % 8;
         if (i > 1) cfg(1, 0, SV[i], 3'(p));
         push(SV[i], (i < 2) ? i + 1 : 3 + p, SA[i]);
         fire(10'h1 << i, 0);
         settle("system");
      end
      cfg(1, 0, 16, 5);
      cfg(1, 0, 17, 2);
      push(17, 5, 1);
      push(16, 8, 1);
      fire(0, 44'h3);
      settle("lower_wins");
      cfg(1, 0, 16, 4);
      cfg(1, 0, 17, 4);
      push(16, 7, 1);
      push(17, 7, 1);
      fire(0, 44'h3);
      settle("tie");
      cfg(1, 1, 2, 0);
      cfg(1, 1, 3, 0);
      push(2, 1, 1);
      push(3, 2, 0);
      push(16, 7, 1);
      fire(10'h3, 44'h1);
      settle("fixed");
      cfg(0, 1, 18, 1);
      fire(0, 44'h4);
      settle("unprivileged");
      push(18, 3, 1);
      cfg(1, 1, 18, 1);
      settle("enable_late");
      cfg(1, 1, 18, 0);
      fire(0, 44'h4);
      settle("disabled");
      cfg(1, 1, 25, 1);
      fire(0, 44'h7c0_0803_fe00);
      settle("reserved");
      cfg(1, 1, 4, 0);
      push(3, 2, 0);
      fire(10'h4, 0);
      settle("escalate");
      repeat (8) begin
         do n = $urandom % 44; while (!impl(n) || n == 2);
         p = $urandom % 8;
         cfg(1, 0, 6'(16 + n), 3'(p));
         cfg(1, 1, 6'(16 + n), 1);
         push(16 + n, 3 + p, 1);
         fire(0, 44'h1 << n);
         settle("random");
      end
      // Second reset must wipe priorities set above
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      check("boot_fetch_req", 8'h01, {7'h0, boot_fetch_req});
      boot_q.push_back(8'h00);
      boot_q.push_back(8'h04);
      rst_n <= 1'b1;
      settle("reset_again");
      cfg(1, 1, 16, 1);
      push(16, 3, 1);
      fire(0, 44'h1);
      settle("priority_again");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
